// ==== hdl/cux_dev.sv ====
/*
  Device end: temperature unit exchange logic. Keeps the working memory
  of operating parameters, takes init data only at restart, saves savable
  parameters to a nonvolatile array and reloads them when switch 8 is on.
  Assumes the host end paces refreshes and restarts.
*/
`timescale 1ns/100ps
module cux_dev
  import cux_pkg::*;
(
  input  wire logic                        sys_clk_i,
  input  wire logic                        arst_n_i,
  cux_if.dev                               link,
  input  wire logic                        dip_sw8_i,
  input  wire cux_pkg::cux_word_t [NLOOP-1:0]  measured_pv_i,
  input  wire logic [NLOOP-1:0]            autotune_done_i,
  input  wire cux_pkg::cux_oppar_t [NLOOP-1:0] autotune_result_i,
  input  wire cux_pkg::cux_word_t [NLOOP-1:0]  ctrl_out_i,
  output cux_pkg::cux_word_t [NLOOP-1:0]   ctrl_out_o,
  output cux_pkg::cux_word_t [NLOOP-1:0]   set_point_o,
  output cux_pkg::cux_init_t [NLOOP-1:0]   init_data_o,
  output cux_pkg::cux_oppar_t [NLOOP-1:0]  oppar_o,
  output logic [NLOOP-1:0]                 autotune_run_o
);
  import cux_pkg::*;

  // Savable part is the first four fields; derivative time keeps its stored value
  function automatic cux_oppar_t savable(input cux_oppar_t w, input cux_oppar_t nv);
    cux_oppar_t r;
    r            = nv;
    r.alarm_sv   = w.alarm_sv;
    r.ctrl_period = w.ctrl_period;
    r.prop_band  = w.prop_band;
    r.integ_time = w.integ_time;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Restart sequencing
  // ---------------------------------------------------------------
  cux_state_t              st_q;
  logic [NV_CNT_W-1:0]     cnt_q;
  logic                    boot_q;   // Forces one restart pass after reset
  logic [NLOOP-1:0]        save_start;
  wire in_restart = (st_q == CUX_RESTART);
  wire restart_end = in_restart && (cnt_q == NV_CNT_W'(RESTART_CYC));

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q   <= CUX_RUN;
      cnt_q  <= '0;
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
      unique case (st_q)
        CUX_RUN: begin
          if (link.restart || boot_q) begin
            st_q  <= CUX_RESTART;
            cnt_q <= NV_CNT_ONE;
          end else if (|save_start) begin
            st_q  <= CUX_SAVE;
            cnt_q <= NV_CNT_ONE;
          end
        end
        CUX_RESTART: begin
          cnt_q <= cnt_q + 1'b1;
          if (restart_end) st_q <= CUX_RUN;
        end
        CUX_SAVE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == NV_CNT_W'(NV_WR_CYC)) st_q <= CUX_RUN;
        end
      endcase
    end
  end
  assign link.restarting = in_restart;

  // ---------------------------------------------------------------
  // Save edge detect and nonvolatile array
  // ---------------------------------------------------------------
  logic [NLOOP-1:0]        save_prev_q;
  logic [NLOOP-1:0]        save_pend_q;
  logic [NLOOP-1:0]        done_q;
  cux_oppar_t [NLOOP-1:0]  nv_mem_q;
  cux_oppar_t [NLOOP-1:0]  work_q;
  wire nv_finish = (st_q == CUX_SAVE) && (cnt_q == NV_CNT_W'(NV_WR_CYC));
  wire [NLOOP-1:0] save_rise = link.save_bit & ~save_prev_q;

  assign save_start = save_pend_q;

  genvar g;
  generate
    for (g = 0; g < NLOOP; g++) begin : g_nv
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          save_prev_q[g] <= 1'b0;
          save_pend_q[g] <= 1'b0;
          done_q[g]      <= 1'b0;
          nv_mem_q[g]    <= '0;
        end else begin
          save_prev_q[g] <= link.save_bit[g];
          if (save_rise[g]) begin
            save_pend_q[g] <= 1'b1;
            done_q[g]      <= 1'b0;
          end else if (nv_finish && save_pend_q[g]) begin
            save_pend_q[g] <= 1'b0;
            done_q[g]      <= 1'b1;
            nv_mem_q[g]    <= savable(work_q[g], nv_mem_q[g]);
          end
        end
      end
    end
  endgenerate
  assign link.save_done = done_q;

  // ---------------------------------------------------------------
  // Working memory, init data and operation data
  // ---------------------------------------------------------------
  cux_init_t [NLOOP-1:0]  init_q;
  cux_word_t [NLOOP-1:0]  sp_q;
  cux_word_t [NLOOP-1:0]  pv_q;
  logic [NLOOP-1:0]       at_q;
  logic [NLOOP-1:0]       calc_q;

  generate
    for (g = 0; g < NLOOP; g++) begin : g_work
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          init_q[g] <= '0;
          sp_q[g]   <= WORD_RST;
          pv_q[g]   <= WORD_RST;
          at_q[g]   <= 1'b0;
          calc_q[g] <= 1'b0;
          work_q[g] <= '0;
        end else if (in_restart) begin
          init_q[g] <= link.init_data[g];
          at_q[g]   <= 1'b0;
          if (dip_sw8_i) begin
            work_q[g] <= nv_mem_q[g];
            calc_q[g] <= 1'b0;
          end
        end else begin
          if (autotune_done_i[g] && at_q[g]) begin
            work_q[g].prop_band  <= autotune_result_i[g].prop_band;
            work_q[g].integ_time <= autotune_result_i[g].integ_time;
            work_q[g].deriv_time <= autotune_result_i[g].deriv_time;
            calc_q[g] <= 1'b1;
            at_q[g]   <= 1'b0;
          end else if (link.refresh) begin
            sp_q[g] <= link.set_point[g];
            pv_q[g] <= measured_pv_i[g];
            // Stop wins over start when both arrive together
            if (link.autotune_stop[g])       at_q[g] <= 1'b0;
            else if (link.autotune_start[g]) at_q[g] <= 1'b1;
            work_q[g].alarm_sv    <= link.oppar_wr[g].alarm_sv;
            work_q[g].ctrl_period <= link.oppar_wr[g].ctrl_period;
            if (!calc_q[g]) begin
              work_q[g].prop_band  <= link.oppar_wr[g].prop_band;
              work_q[g].integ_time <= link.oppar_wr[g].integ_time;
              work_q[g].deriv_time <= link.oppar_wr[g].deriv_time;
            end
          end
        end
      end
      // Inputs stay frozen through restart since pv_q only moves outside restart, in run or save
      assign ctrl_out_o[g] = in_restart ? ZERO_VOLT : ctrl_out_i[g];
    end
  endgenerate

  assign link.process_value = pv_q;
  assign link.oppar_rd      = work_q;
  assign link.pid_calc_flag = calc_q;
  assign link.autotune_busy = at_q;
  assign set_point_o        = sp_q;
  assign init_data_o        = init_q;
  assign oppar_o            = work_q;
  assign autotune_run_o     = at_q;
endmodule : cux_dev

// ==== hdl/cux_pkg.sv ====
/*
  Constants and types shared by both ends of the data exchange link between
  the controller (host) and the two-loop temperature unit (device).
  Assumes one clock, one asynchronous active-low reset, and that the
  refresh strobe is generated by the host end.
*/
//
// Contract
// - Operation data exchanged every refresh period
// - Initialization data taken only at reset/restart
// - Operating parameters exchanged every refresh period; host reads them back only during restart
// - Host restarts unit by numbered restart bit
// - During restart outputs zero, inputs held
// - Host writes land in volatile working memory
// - Save bit rise copies loop params to nonvolatile
// - Save-completed flag set after nonvolatile write
// - Switch 8 on reloads stored params at restart
// - Autotune end writes constants into working memory
// - Host limits number of nonvolatile saves
// - Host retains init and parameter values
package cux_pkg;
  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int unsigned NLOOP       = 2;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned UNIT_W      = 7;
  localparam logic [UNIT_W-1:0] UNIT_MAX = 7'h5E;  // Highest unit number, 94
  localparam logic [UNIT_W-1:0] UNIT_MIN = 7'h00;
  // Refresh period in cycles of the 100 MHz clock
  localparam int unsigned REFRESH_NS  = 1000;
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned REFRESH_CYC = REFRESH_NS / CLK_NS;
  localparam int unsigned REF_CNT_W   = 8;
  // Time taken by one nonvolatile write
  localparam int unsigned NV_WR_NS    = 500;
  localparam int unsigned NV_WR_CYC   = NV_WR_NS / CLK_NS;
  localparam int unsigned NV_CNT_W    = 8;
  // Restart hold time
  localparam int unsigned RESTART_NS  = 200;
  localparam int unsigned RESTART_CYC = RESTART_NS / CLK_NS;
  localparam logic [WORD_W-1:0] ZERO_VOLT = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;
  localparam logic [NV_CNT_W-1:0] NV_CNT_ONE = 8'h01;

  typedef logic [WORD_W-1:0] cux_word_t;

  // Operating parameters of one loop; the first four are savable
  typedef struct packed {
    cux_word_t alarm_sv;
    cux_word_t ctrl_period;
    cux_word_t prop_band;
    cux_word_t integ_time;
    cux_word_t deriv_time;
  } cux_oppar_t;

  // Initialization data of one loop
  typedef struct packed {
    cux_word_t alarm_mode;
    cux_word_t alarm_hyst;
  } cux_init_t;

  typedef enum logic [2:0] {
    CUX_RUN     = 3'b001,
    CUX_RESTART = 3'b010,
    CUX_SAVE    = 3'b100
  } cux_state_t;
endpackage : cux_pkg

// ==== hdl/cux_if.sv ====
/*
  Interface joining the host end and the device end of the exchange.
  Assumes both ends share sys_clk_i; the host drives the refresh strobe.
*/
`timescale 1ns/100ps
interface cux_if;
  import cux_pkg::*;
  logic                    refresh;            // One-cycle refresh strobe
  logic                    restart;            // Restart pulse to this unit
  // Operation data
  cux_word_t [NLOOP-1:0]   process_value;
  cux_word_t [NLOOP-1:0]   set_point;
  logic      [NLOOP-1:0]   autotune_start;
  logic      [NLOOP-1:0]   autotune_stop;
  logic      [NLOOP-1:0]   autotune_busy;
  // Initialization data and operating parameters
  cux_init_t  [NLOOP-1:0]  init_data;
  cux_oppar_t [NLOOP-1:0]  oppar_wr;
  cux_oppar_t [NLOOP-1:0]  oppar_rd;
  logic       [NLOOP-1:0]  pid_calc_flag;
  logic       [NLOOP-1:0]  save_bit;
  logic       [NLOOP-1:0]  save_done;
  logic                    restarting;

  modport host (
    output refresh, restart, set_point, autotune_start, autotune_stop,
           init_data, oppar_wr, save_bit,
    input  process_value, autotune_busy, oppar_rd, pid_calc_flag, save_done,
           restarting
  );
  modport dev (
    input  refresh, restart, set_point, autotune_start, autotune_stop,
           init_data, oppar_wr, save_bit,
    output process_value, autotune_busy, oppar_rd, pid_calc_flag, save_done,
           restarting
  );
endinterface : cux_if

// ==== hdl/cux_host.sv ====
/*
  Host end: controller side of the exchange. Generates the refresh period,
  holds the battery-backed copies of init data and parameters, decodes the
  numbered restart bit and hands back save bits after completion.
  Assumes the user program drives the plain user-side ports.
*/
`timescale 1ns/100ps
module cux_host
  import cux_pkg::*;
(
  input  wire logic                        sys_clk_i,
  input  wire logic                        arst_n_i,
  cux_if.host                              link,
  input  wire logic [UNIT_W-1:0]           my_unit_i,
  input  wire logic [UNIT_W-1:0]           restart_unit_i,
  input  wire logic                        unit_restart_request_bit_i,
  input  wire cux_pkg::cux_word_t [NLOOP-1:0]  set_point_i,
  input  wire logic [NLOOP-1:0]            autotune_start_i,
  input  wire logic [NLOOP-1:0]            autotune_stop_i,
  input  wire cux_pkg::cux_init_t [NLOOP-1:0]  init_data_i,
  input  wire cux_pkg::cux_oppar_t [NLOOP-1:0] oppar_i,
  input  wire logic                        oppar_we_i,
  input  wire logic [NLOOP-1:0]            save_req_i,
  output logic [NLOOP-1:0]                 save_busy_o,
  output cux_pkg::cux_word_t [NLOOP-1:0]   process_value_o,
  output cux_pkg::cux_oppar_t [NLOOP-1:0]  oppar_o
);
  import cux_pkg::*;

  // ---------------------------------------------------------------
  // Refresh divider
  // ---------------------------------------------------------------
  logic [REF_CNT_W-1:0] ref_cnt_q;
  wire                  ref_tick = (ref_cnt_q == REF_CNT_W'(REFRESH_CYC - 1));

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) ref_cnt_q <= '0;
    else           ref_cnt_q <= ref_tick ? '0 : ref_cnt_q + 1'b1;
  end
  assign link.refresh = ref_tick;

  // ---------------------------------------------------------------
  // Restart decode
  // ---------------------------------------------------------------
  // Out-of-range unit numbers are dropped rather than aliased
  wire unit_ok = (restart_unit_i <= UNIT_MAX) && (restart_unit_i >= UNIT_MIN);
  logic restart_q;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) restart_q <= 1'b0;
    else           restart_q <= unit_restart_request_bit_i && unit_ok
                                && (restart_unit_i == my_unit_i);
  end
  assign link.restart = restart_q;

  // ---------------------------------------------------------------
  // Retained copies and operation data
  // ---------------------------------------------------------------
  cux_init_t  [NLOOP-1:0] init_q;
  cux_oppar_t [NLOOP-1:0] oppar_q;
  cux_word_t  [NLOOP-1:0] sp_q;
  cux_word_t  [NLOOP-1:0] pv_q;
  logic [NLOOP-1:0]       ats_q;
  logic [NLOOP-1:0]       atp_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_q  <= '0;
      oppar_q <= '0;
      sp_q    <= '0;
      pv_q    <= '0;
      ats_q   <= '0;
      atp_q   <= '0;
    end else begin
      init_q <= init_data_i;
      // Read back only while the unit restarts, when a reload may replace
      // its settings; reading on every refresh would bounce old values back
      if (oppar_we_i) begin
        oppar_q <= oppar_i;
      end else if (link.restarting) begin
        oppar_q <= link.oppar_rd;
      end
      if (ref_tick) begin
        sp_q  <= set_point_i;
        ats_q <= autotune_start_i;
        atp_q <= autotune_stop_i;
        pv_q  <= link.process_value;
      end
    end
  end
  assign link.init_data      = init_q;
  assign link.oppar_wr       = oppar_q;
  assign link.set_point      = sp_q;
  assign link.autotune_start = ats_q;
  assign link.autotune_stop  = atp_q;
  assign process_value_o     = pv_q;
  assign oppar_o             = oppar_q;

  // ---------------------------------------------------------------
  // Save handshake per loop
  // ---------------------------------------------------------------
  // A save request is only raised once per user request, which keeps the
  // number of nonvolatile writes down to what the program asks for.
  // The done flag of an earlier save still stands when the next one is
  // raised, so only a fresh rise of it ends the request.
  logic [NLOOP-1:0] save_q;
  logic [NLOOP-1:0] done_prev_q;
  wire  [NLOOP-1:0] done_rise = link.save_done & ~done_prev_q;
  genvar g;
  generate
    for (g = 0; g < NLOOP; g++) begin : g_save
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          save_q[g]      <= 1'b0;
          done_prev_q[g] <= 1'b0;
        end else begin
          done_prev_q[g] <= link.save_done[g];
          if (save_q[g] && done_rise[g])        save_q[g] <= 1'b0;
          else if (save_req_i[g] && !save_q[g]) save_q[g] <= 1'b1;
        end
      end
    end
  endgenerate
  assign link.save_bit = save_q;
  assign save_busy_o   = save_q;
endmodule : cux_host

// ==== testbench/cux_link_monitor.sv ====
/*
  Checker for the exchange link between the host end and the device end.
  Assumes it is instantiated beside cux_if and sees its signals as inputs.
*/
`timescale 1ns/100ps
module cux_link_monitor (
  input  wire logic                             sys_clk_i,
  input  wire logic                             arst_n_i,
  input  wire logic                             refresh,
  input  wire logic                             restart,
  input  wire logic                             restarting,
  input  wire cux_pkg::cux_word_t [cux_pkg::NLOOP-1:0] process_value,
  input  wire logic [cux_pkg::NLOOP-1:0]        save_bit,
  input  wire logic [cux_pkg::NLOOP-1:0]        save_done
);
  import cux_pkg::*;
  localparam logic [7:0] RS_LEN = 8'(RESTART_CYC);
  logic [7:0] rs_cnt_q;
  logic       busy_save;
  // ---------------------------------------------------------------
  // Restart length counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rs_cnt_q <= 8'h00;
    else rs_cnt_q <= restarting ? rs_cnt_q + 8'h01 : 8'h00;
  end
  // A restart pulse is dropped while a save runs, so it is exempt then
  assign busy_save = |(save_bit & ~save_done);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  refresh_period_a: assert property (refresh |-> ##100 refresh)
    else $error("refresh period wrong");
  refresh_pulse_a: assert property (refresh |=> !refresh)
    else $error("refresh longer than one cycle");
  restart_pulse_a: assert property (restart |=> !restart)
    else $error("restart longer than one cycle");
  restart_enter_a: assert property (restart && !busy_save |-> ##[1:2] restarting)
    else $error("restart not entered");
  restart_len_a: assert property (rs_cnt_q <= RS_LEN)
    else $error("restart too long");
  restart_end_a: assert property ($fell(restarting) |-> rs_cnt_q == RS_LEN)
    else $error("restart too short");
  pv_hold_a: assert property (restarting ##1 restarting |-> $stable(process_value))
    else $error("input data moved during restart");
  save_time_a: assert property ($rose(save_bit[0]) |-> ##[45:60] save_done[0])
    else $error("save completion late");
  save_early_a: assert property ($rose(save_done[1]) |-> $past(save_bit[1], 45))
    else $error("save completion early");
  save_drop_a: assert property ($rose(save_done[0]) |-> ##[1:3] !save_bit[0])
    else $error("save bit not returned");
endmodule // cux_link_monitor

// ==== testbench/control_unit_data_exchange_bench.sv ====
/*
  Self-checking bench: host end and device end joined by cux_if.
  Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/100ps
module control_unit_data_exchange_bench;
  import cux_pkg::*;
  typedef struct packed {cux_word_t sp; cux_word_t pv; cux_word_t par;} cux_row_t;
  localparam cux_row_t ROWS [3] = '{'{16'h0000, 16'hFFFF, 16'h8000},
    '{16'h1234, 16'h00FF, 16'h7FFF}, '{16'hFFFF, 16'h0000, 16'h0001}};
  logic                   sys_clk_i, arst_n_i, req, oppar_we, sw8;
  logic [UNIT_W-1:0]      restart_unit;
  cux_word_t [NLOOP-1:0]  sp, pv, cout, h_pv, d_sp, d_cout;
  logic [NLOOP-1:0]       at_start, at_stop, at_done, save_req, save_busy, at_run;
  cux_init_t [NLOOP-1:0]  init, d_init;
  cux_oppar_t [NLOOP-1:0] par, at_res, h_par, d_par;
  int                     error_cnt, comparisons;
  cux_if bus ();
  cux_host u_cux_host (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .link(bus.host),
    .my_unit_i(UNIT_MAX), .restart_unit_i(restart_unit), .unit_restart_request_bit_i(req),
    .set_point_i(sp), .autotune_start_i(at_start), .autotune_stop_i(at_stop),
    .init_data_i(init), .oppar_i(par), .oppar_we_i(oppar_we), .save_req_i(save_req),
    .save_busy_o(save_busy), .process_value_o(h_pv), .oppar_o(h_par));
  cux_dev u_cux_dev (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .link(bus.dev),
    .dip_sw8_i(sw8), .measured_pv_i(pv), .autotune_done_i(at_done),
    .autotune_result_i(at_res), .ctrl_out_i(cout), .ctrl_out_o(d_cout), .set_point_o(d_sp),
    .init_data_o(d_init), .oppar_o(d_par), .autotune_run_o(at_run));
  cux_link_monitor u_cux_link_monitor (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .refresh(bus.refresh), .restart(bus.restart), .restarting(bus.restarting),
    .process_value(bus.process_value), .save_bit(bus.save_bit), .save_done(bus.save_done));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Loads the retained copy; loop 0 gets a in its first two fields, b in the PID ones
  task automatic load(input cux_word_t a, input cux_word_t b, input cux_word_t c);
    par[0] = '{a, a, b, b, b};
    par[1] = '{c, c, c, c, c};
    oppar_we = 1'b1;
    tick(1);
    oppar_we = 1'b0;
  endtask
  task automatic ask_restart(input logic [UNIT_W-1:0] u);
    restart_unit = u;
    req = 1'b1;
    tick(1);
    req = 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Whole run is near 2200 cycles, so this only trips on a hang
  initial begin : watchdog
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    summarize();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    logic [UNIT_W-1:0] u [3];
    arst_n_i = 1'b0; req = 1'b0; oppar_we = 1'b0; sw8 = 1'b0; restart_unit = '0;
    sp = '0; pv = '0; cout = {16'h0C0C, 16'h0A0A}; at_start = '0; at_stop = '0;
    at_done = '0; save_req = '0; init = '0; par = '0; at_res = '0;
    error_cnt = 0; comparisons = 0;
    u = '{7'h5F, 7'h03, 7'h5E};
    repeat (16) @(posedge sys_clk_i);
    #1 arst_n_i = 1'b1;
    check(d_sp[0], WORD_RST);
    check(d_par[1].alarm_sv, WORD_RST);
    check(h_pv[0], WORD_RST);
    $display("test reset done");
    tick(30);
    for (int i = 0; i < 3; i++) begin
      sp = {~ROWS[i].sp, ROWS[i].sp};
      pv = {~ROWS[i].pv, ROWS[i].pv};
      load(ROWS[i].par, ROWS[i].par ^ 16'h00F0, ~ROWS[i].par);
      tick(210);
      check(d_sp[0], sp[0]);
      check(d_sp[1], sp[1]);
      check(h_pv[0], pv[0]);
      check(h_pv[1], pv[1]);
      check(d_par[0].alarm_sv, ROWS[i].par);
      check(d_par[0].prop_band, ROWS[i].par ^ 16'h00F0);
      check(d_par[1].deriv_time, ~ROWS[i].par);
      check(h_par[0].ctrl_period, ROWS[i].par);
      check(d_cout[1], cout[1]);
    end
    $display("test rows done");
    init = '{2{'{16'h0011, 16'h0022}}};
    load(16'h1111, 16'h1111, 16'h1111);
    ask_restart(UNIT_MAX);
    tick(50);
    check(d_init[0].alarm_mode, 16'h0011);
    init = '{2{'{16'h0033, 16'h0044}}};
    load(16'h1111, 16'h1111, 16'h1111);
    tick(210);
    check(d_init[1].alarm_hyst, 16'h0022);
    for (int i = 0; i < 3; i++) begin
      ask_restart(u[i]);
      tick(5);
      check(bus.restarting, i == 2);
      check(d_cout[0], (i == 2) ? ZERO_VOLT : cout[0]);
      tick(30);
    end
    check(d_init[1].alarm_hyst, 16'h0044);
    $display("test restart done");
    at_start[0] = 1'b1;
    tick(210);
    check(at_run[0], 1'b1);
    at_stop[0] = 1'b1;
    tick(210);
    check(at_run[0], 1'b0);
    at_stop = '0;
    tick(210);
    check(at_run[0], 1'b1);
    at_start = '0;
    at_res[0] = '{16'h0000, 16'h0000, 16'h0777, 16'h0888, 16'h0999};
    at_done[0] = 1'b1;
    tick(1);
    at_done = '0;
    tick(2);
    check(d_par[0].prop_band, 16'h0777);
    check(bus.pid_calc_flag[0], 1'b1);
    load(16'h4444, 16'h5555, 16'h6666);
    tick(210);
    check(d_par[0].prop_band, 16'h0777);
    check(d_par[0].alarm_sv, 16'h4444);
    check(d_par[1].prop_band, 16'h6666);
    $display("test autotune done");
    save_req = 2'b11;
    tick(1);
    save_req = '0;
    k = 0;
    while (bus.save_done[1] !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    check(bus.save_done[1], 1'b1);
    check(bus.save_done[0], 1'b1);
    tick(4);
    check(save_busy[1], 1'b0);
    check(save_busy[0], 1'b0);
    load(16'h2222, 16'h3333, 16'h2222);
    tick(210);
    check(d_par[1].alarm_sv, 16'h2222);
    sw8 = 1'b1;
    ask_restart(UNIT_MAX);
    k = 0;
    while (bus.restarting !== 1'b1 && k < 10) begin
      tick(1);
      k++;
    end
    while (bus.restarting === 1'b1 && k < 60) begin
      tick(1);
      k++;
    end
    check(d_par[1].alarm_sv, 16'h6666);
    check(bus.pid_calc_flag[0], 1'b0);
    check(h_par[1].alarm_sv, 16'h6666);
    $display("test save done");
    summarize();
  end
endmodule // control_unit_data_exchange_bench
